//--- asq_pkg.sv
package asq_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE_A = 8'h00;
    localparam logic [7:0] OFS_MODE_C = 8'h04;
    localparam logic [7:0] OFS_SEL = 8'h08;
    localparam logic [7:0] OFS_RES0 = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    // Mode register A fields
    localparam int CE_BIT = 7;
    localparam int EF_BIT = 6;
    localparam int ONESHOT_BIT = 5;
    localparam int SCAN_BIT = 4;
    localparam int HWTRIG_BIT = 1;
    // Mode register C field
    localparam int BUF4_BIT = 0;
    // Interrupt status bits
    localparam int ST_END_BIT = 0;
    localparam int ST_STALL_BIT = 1;
    // Sizes and reset values
    localparam int NCH = 4;
    localparam int RES_W = 10;
    localparam logic [1:0] LAST_SLOT = 2'h3;
    localparam logic [1:0] CH_RST = 2'h0;
    localparam logic [RES_W-1:0] RES_RST = 10'h000;
    localparam logic [1:0] IRQ_RST = 2'h0;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } asq_state_e;

    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } asq_aph_s;

    // Converter core request
    typedef struct packed {
        logic start;
        logic [1:0] channel;
    } asq_conv_req_s;
endpackage : asq_pkg

//--- asq_top.sv
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module asq_top
    import asq_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic hw_trig,
    output asq_conv_req_s conv_req,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_data,
    output logic conversion_end_irq
);
    asq_aph_s aph_q;
    asq_state_e state_q;
    logic ce_q, oneshot_q, scan_q, hwtrig_q, buf4_q;
    logic [1:0] sel_q, ch_q, slot_q;
    logic [RES_W-1:0] result_q [NCH];
    logic [1:0] stat_q, mask_q;
    logic wr_mode_a, wr_mode_c, wr_sel, wr_ctl;
    logic ce_d, oneshot_d, scan_d, buf4_d;
    logic [1:0] sel_d;
    logic last_conv, done_last, hazard, restart, store_en, end_evt;
    logic [1:0] store_idx;
    logic [1:0] stat_d;
    logic [4*RES_W-1:0] result_flat;

    // Word index of a byte offset, used by decode of both reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction : hit

    // Result slot for a finished conversion
    function automatic logic [1:0] slot_of(input logic scan, input logic b4,
                                           input logic [1:0] ch, input logic [1:0] slot,
                                           input logic [1:0] sel);
        if (scan) begin
            return ch;
        end else if (b4) begin
            return slot;
        end
        return sel;
    endfunction : slot_of

    // Address phase capture; zero wait states so hready is always ours
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aph_q <= '0;
        end else begin
            aph_q.valid <= hsel & htrans[1] & hready;
            aph_q.write <= hwrite;
            aph_q.addr <= haddr[7:0];
        end
    end

    // Response is fixed: always ready, always OKAY
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Write strobes land in the data phase
    always_comb begin
        wr_mode_a = aph_q.valid & aph_q.write & hit(aph_q.addr, OFS_MODE_A);
        wr_mode_c = aph_q.valid & aph_q.write & hit(aph_q.addr, OFS_MODE_C);
        wr_sel = aph_q.valid & aph_q.write & hit(aph_q.addr, OFS_SEL);
        wr_ctl = wr_mode_a | wr_mode_c | wr_sel;
    end

    // Next configuration, so a restart sees the freshly written settings
    always_comb begin
        ce_d = wr_mode_a ? hwdata[CE_BIT] : ce_q;
        oneshot_d = wr_mode_a ? hwdata[ONESHOT_BIT] : oneshot_q;
        scan_d = wr_mode_a ? hwdata[SCAN_BIT] : scan_q;
        buf4_d = wr_mode_c ? hwdata[BUF4_BIT] : buf4_q;
        sel_d = wr_sel ? hwdata[1:0] : sel_q;
    end

    // Pass end, coincidence detection and restart decision
    always_comb begin
        last_conv = scan_q ? (ch_q == sel_q) : (buf4_q ? (slot_q == LAST_SLOT) : 1'b1);
        done_last = (state_q == ST_CONV) & conv_done & last_conv;
        hazard = ce_q & oneshot_q & ~hwtrig_q & done_last & wr_ctl;
        restart = ~hazard & ce_d & ((wr_mode_a & hwdata[CE_BIT]) | (wr_ctl & ce_q));
        store_en = (state_q == ST_CONV) & conv_done & ce_q & ~hazard & ~restart;
        store_idx = slot_of(scan_q, buf4_q, ch_q, slot_q, sel_q);
        end_evt = store_en & last_conv;
    end

    // Control registers; a write during the stall is still kept
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ce_q <= 1'b0;
            oneshot_q <= 1'b0;
            scan_q <= 1'b0;
            hwtrig_q <= 1'b0;
            buf4_q <= 1'b0;
            sel_q <= CH_RST;
        end else begin
            ce_q <= ce_d;
            oneshot_q <= oneshot_d;
            scan_q <= scan_d;
            buf4_q <= buf4_d;
            sel_q <= sel_d;
            if (wr_mode_a) begin
                hwtrig_q <= hwdata[HWTRIG_BIT];
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            ch_q <= CH_RST;
            slot_q <= CH_RST;
            conv_req <= '0;
        end else begin
            conv_req.start <= 1'b0;
            if (hazard) begin
                state_q <= ST_IDLE;
            end else if (restart) begin
                state_q <= ST_CONV;
                ch_q <= CH_RST;
                slot_q <= CH_RST;
                conv_req.start <= 1'b1;
                conv_req.channel <= scan_d ? CH_RST : sel_d;
            end else if (!ce_d) begin
                state_q <= ST_IDLE;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (oneshot_q && hwtrig_q && hw_trig) begin
                            state_q <= ST_CONV;
                            ch_q <= CH_RST;
                            slot_q <= CH_RST;
                            conv_req.start <= 1'b1;
                            conv_req.channel <= scan_q ? CH_RST : sel_q;
                        end
                    end
                    ST_CONV: begin
                        if (conv_done) begin
                            if (last_conv && oneshot_q) begin
                                state_q <= ST_IDLE;
                            end else if (last_conv) begin
                                ch_q <= CH_RST;
                                slot_q <= CH_RST;
                                conv_req.start <= 1'b1;
                                conv_req.channel <= scan_q ? CH_RST : sel_q;
                            end else begin
                                ch_q <= ch_q + 2'h1;
                                slot_q <= slot_q + 2'h1;
                                conv_req.start <= 1'b1;
                                conv_req.channel <= scan_q ? ch_q + 2'h1 : sel_q;
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Result storage; ten bits per channel
    // ten-bit results
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < NCH; i++) begin
                result_q[i] <= RES_RST;
            end
        end else if (store_en) begin
            result_q[store_idx] <= conv_data;
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_comb begin
        stat_d = stat_q;
        if (aph_q.valid && aph_q.write && hit(aph_q.addr, OFS_IRQ_STAT)) begin
            stat_d = stat_q & ~hwdata[1:0];
        end
        if (end_evt) begin
            stat_d[ST_END_BIT] = 1'b1;
        end
        if (hazard) begin
            stat_d[ST_STALL_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            stat_q <= IRQ_RST;
            mask_q <= IRQ_RST;
            conversion_end_irq <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (aph_q.valid && aph_q.write && hit(aph_q.addr, OFS_IRQ_MASK)) begin
                mask_q <= hwdata[1:0];
            end
            conversion_end_irq <= |(stat_d & mask_q);
        end
    end

    // Read data is registered in the address phase, shown in the data phase
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hrdata <= '0;
        end else if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata <= '0;
            if (hit(haddr[7:0], OFS_MODE_A)) begin
                hrdata[CE_BIT] <= ce_d;
                hrdata[EF_BIT] <= (state_q == ST_CONV);
                hrdata[ONESHOT_BIT] <= oneshot_d;
                hrdata[SCAN_BIT] <= scan_d;
                hrdata[HWTRIG_BIT] <= hwtrig_q;
            end else if (hit(haddr[7:0], OFS_MODE_C)) begin
                hrdata[BUF4_BIT] <= buf4_d;
            end else if (hit(haddr[7:0], OFS_SEL)) begin
                hrdata[1:0] <= sel_d;
            end else if (haddr[7:4] == OFS_RES0[7:4]) begin
                hrdata[RES_W-1:0] <= result_q[haddr[3:2]];
            end else if (hit(haddr[7:0], OFS_IRQ_STAT)) begin
                hrdata[1:0] <= stat_q;
            end else if (hit(haddr[7:0], OFS_IRQ_MASK)) begin
                hrdata[1:0] <= mask_q;
            end
        end
    end

    assign result_flat = {result_q[3], result_q[2], result_q[1], result_q[0]};

    // Stall leaves enable set, unless the same write clears CE, and the converter idle
    property p_stall_idle;
        @(posedge core_clk) disable iff (srst)
        hazard && !(wr_mode_a && !hwdata[CE_BIT]) |=> ce_q && state_q == ST_IDLE;
    endproperty
    a_stall_idle: assert property (p_stall_idle) else $error("stall did not idle");

    property p_stall_drop;
        @(posedge core_clk) disable iff (srst)
        hazard |=> result_flat == $past(result_flat) && !$rose(stat_q[ST_END_BIT]);
    endproperty
    a_stall_drop: assert property (p_stall_drop) else $error("stalled result kept");

    property p_sel_kept;
        @(posedge core_clk) disable iff (srst)
        wr_sel |=> sel_q == $past(hwdata[1:0]);
    endproperty
    a_sel_kept: assert property (p_sel_kept) else $error("select write lost");

    property p_ce_restart;
        @(posedge core_clk) disable iff (srst)
        wr_mode_a && hwdata[CE_BIT] && !hazard |=> conv_req.start && state_q == ST_CONV;
    endproperty
    a_ce_restart: assert property (p_ce_restart) else $error("enable did not start");

    property p_cont_repeat;
        @(posedge core_clk) disable iff (srst)
        done_last && !oneshot_q && !wr_ctl && ce_q |=> conv_req.start;
    endproperty
    a_cont_repeat: assert property (p_cont_repeat) else $error("continuous stopped");

    property p_oneshot_end;
        @(posedge core_clk) disable iff (srst)
        done_last && oneshot_q && !wr_ctl |=> state_q == ST_IDLE && !conv_req.start;
    endproperty
    a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot kept going");

    property p_store_idx;
        @(posedge core_clk) disable iff (srst)
        store_en |=> result_q[$past(store_idx)] == $past(conv_data);
    endproperty
    a_store_idx: assert property (p_store_idx) else $error("result misplaced");

    property p_one_buf_irq;
        @(posedge core_clk) disable iff (srst)
        store_en && !scan_q && !buf4_q |=> stat_q[ST_END_BIT];
    endproperty
    a_one_buf_irq: assert property (p_one_buf_irq) else $error("no end event");

    property p_buf4_step;
        @(posedge core_clk) disable iff (srst)
        ce_d && store_en && !scan_q && buf4_q && slot_q != LAST_SLOT
            |=> slot_q == $past(slot_q) + 2'h1;
    endproperty
    a_buf4_step: assert property (p_buf4_step) else $error("buffer slot stuck");

    property p_scan_next;
        @(posedge core_clk) disable iff (srst)
        ce_d && store_en && scan_q && !last_conv |=> conv_req.channel == $past(ch_q) + 2'h1;
    endproperty
    a_scan_next: assert property (p_scan_next) else $error("scan order wrong");

    property p_hw_start;
        @(posedge core_clk) disable iff (srst)
        state_q == ST_IDLE && ce_q && oneshot_q && hwtrig_q && hw_trig && !wr_ctl
            |=> conv_req.start && state_q == ST_CONV;
    endproperty
    a_hw_start: assert property (p_hw_start) else $error("trigger ignored");

    property p_cont_busy;
        @(posedge core_clk) disable iff (srst)
        state_q == ST_CONV && ce_q && !oneshot_q && !wr_ctl |=> state_q == ST_CONV;
    endproperty
    a_cont_busy: assert property (p_cont_busy) else $error("continuous went idle");

    property p_res_hold;
        @(posedge core_clk) disable iff (srst)
        !store_en |=> result_flat == $past(result_flat);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result changed unasked");

    property p_end_sticky;
        @(posedge core_clk) disable iff (srst)
        stat_q[ST_END_BIT] && !(aph_q.valid && aph_q.write && hit(aph_q.addr, OFS_IRQ_STAT))
            |=> stat_q[ST_END_BIT];
    endproperty
    a_end_sticky: assert property (p_end_sticky) else $error("end flag lost");

    property p_irq_level;
        @(posedge core_clk) disable iff (srst)
        1'b1 |=> conversion_end_irq == |(stat_q & $past(mask_q));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule : asq_top

//--- asq_conv_model.sv
`timescale 1ns/1ps
module asq_conv_model
    import asq_pkg::*;
#(
    parameter int DLY = 5
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire asq_conv_req_s conv_req,
    input wire logic stall,
    input wire logic [7:0] base,
    output logic conv_done,
    output logic [RES_W-1:0] conv_data
);
    logic busy_q;
    logic [3:0] cnt_q;
    logic [1:0] ch_q;

    // A new start aborts the old one; data toggles when not valid
    // ten-bit result
    always_ff @(posedge core_clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (srst) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            ch_q <= 2'h0;
            conv_data <= 10'h155;
        end else if (conv_req.start) begin
            busy_q <= 1'b1;
            cnt_q <= 4'h0;
            ch_q <= conv_req.channel;
        end else if (busy_q) begin
            if (cnt_q != 4'(DLY)) begin
                cnt_q <= cnt_q + 4'h1;
            end else if (!stall) begin
                busy_q <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= {base, ch_q}; // Stall holds the core to align events
            end
        end
    end
endmodule : asq_conv_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench
    import asq_pkg::*;
;
    localparam logic [31:0] CE_M = 32'h1 << CE_BIT;
    localparam logic [31:0] EF_M = 32'h1 << EF_BIT;
    localparam logic [31:0] ONE_M = 32'h1 << ONESHOT_BIT;
    localparam logic [31:0] SCN_M = 32'h1 << SCAN_BIT;
    localparam logic [31:0] HW_M = 32'h1 << HWTRIG_BIT;
    logic core_clk, srst, hwrite, hw_trig, stall, hreadyout, hresp, conv_done, irq;
    logic [1:0] htrans;
    logic [7:0] base;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [RES_W-1:0] conv_data;
    asq_conv_req_s conv_req;
    int fail_count, cmp_count;

    asq_top dut (.core_clk(core_clk), .srst(srst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .hw_trig(hw_trig), .conv_req(conv_req), .conv_done(conv_done),
        .conv_data(conv_data), .conversion_end_irq(irq));
    asq_conv_model #(.DLY(5)) core (.core_clk(core_clk), .srst(srst), .conv_req(conv_req),
        .stall(stall), .base(base), .conv_done(conv_done), .conv_data(conv_data));

    // Free-running clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Expected result word for a channel
    function automatic logic [31:0] res(input logic [7:0] b, input logic [1:0] c);
        return {22'h0, b, c};
    endfunction : res

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One AHB single transfer; read data taken at the data-phase edge
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(a, 1'b0, 32'h0);
        chk(nm, rd, e);
    endtask : rchk

    task irqc(input logic [31:0] e);
        chk("irq", {31'h0, irq}, e);
    endtask : irqc

    // First edge skipped so a stale level is not taken as new
    task wait_irq;
        @(posedge core_clk);
        for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge core_clk);
    endtask : wait_irq

    task poll;
        for (int i = 0; i < 60; i++) begin
            bus(OFS_IRQ_STAT, 1'b0, 32'h0);
            if (rd[ST_END_BIT] === 1'b1) break;
        end
    endtask : poll

    task t_reset;
        chk("hreadyout", {31'h0, hreadyout}, 32'h1);
        chk("hresp", {31'h0, hresp}, 32'h0);
        rchk(OFS_MODE_A, 32'h0, "mode_a");
        rchk(OFS_MODE_C, 32'h0, "mode_c");
        rchk(OFS_SEL, 32'h0, "sel");
        rchk(OFS_RES0, 32'h0, "res0");
        rchk(8'h40, 32'h0, "unmapped");
        irqc(32'h0);
        $display("test reset done");
    endtask : t_reset

    task t_cont;
        base <= 8'h11;
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_SEL, 32'h2);
        wr(OFS_MODE_A, CE_M);
        wait_irq;
        irqc(32'h1);
        rchk(OFS_RES0 + 8'h8, res(8'h11, 2'h2), "res2");
        rchk(OFS_MODE_A, CE_M | EF_M, "mode_a");
        wr(OFS_IRQ_STAT, 32'h1);
        wait_irq;
        irqc(32'h1);
        wr(OFS_MODE_A, 32'h0);
        wr(OFS_IRQ_STAT, 32'h1);
        repeat (20) @(posedge core_clk);
        irqc(32'h0);
        rchk(OFS_IRQ_STAT, 32'h0, "stat");
        $display("test continuous select done");
    endtask : t_cont

    // Continuous scan over channels 0 and 1
    task t_cscan;
        base <= 8'h66;
        wr(OFS_SEL, 32'h1);
        wr(OFS_MODE_A, CE_M | SCN_M);
        wait_irq;
        irqc(32'h1);
        rchk(OFS_RES0 + 8'h4, res(8'h66, 2'h1), "cres1");
        wr(OFS_IRQ_STAT, 32'h1);
        wait_irq;
        irqc(32'h1);
        rchk(OFS_RES0, res(8'h66, 2'h0), "cres0");
        wr(OFS_MODE_A, 32'h0);
        wr(OFS_IRQ_STAT, 32'h1);
        $display("test continuous scan done");
    endtask : t_cscan

    task t_scan;
        base <= 8'h22;
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_SEL, 32'h1);
        wr(OFS_MODE_A, CE_M | ONE_M | SCN_M);
        poll;
        irqc(32'h0);
        rchk(OFS_RES0, res(8'h22, 2'h0), "res0");
        rchk(OFS_RES0 + 8'h4, res(8'h22, 2'h1), "res1");
        rchk(OFS_MODE_A, CE_M | ONE_M | SCN_M, "mode_a");
        rchk(OFS_IRQ_STAT, 32'h1, "stat");
        wr(OFS_IRQ_MASK, 32'h1);
        // The mask lands one edge before the interrupt level follows it
        repeat (2) @(posedge core_clk);
        irqc(32'h1);
        wr(OFS_IRQ_STAT, 32'h1);
        @(posedge core_clk);
        irqc(32'h0);
        $display("test one-shot scan done");
    endtask : t_scan

    task t_buf4;
        rchk(OFS_MODE_A, CE_M | ONE_M | SCN_M, "idle");
        base <= 8'h33;
        wr(OFS_MODE_A, 32'h0);
        wr(OFS_MODE_C, 32'h1);
        wr(OFS_SEL, 32'h3);
        // Enable write starts the first pass by itself
        wr(OFS_MODE_A, CE_M | ONE_M | HW_M);
        poll;
        for (int i = 0; i < 4; i++) rchk(OFS_RES0 + 8'(4 * i), res(8'h33, 2'h3), "resb");
        // Second pass comes from the trigger pin while idle
        base <= 8'h3a;
        wr(OFS_IRQ_STAT, 32'h1);
        hw_trig <= 1'b1;
        @(posedge core_clk);
        hw_trig <= 1'b0;
        poll;
        rchk(OFS_IRQ_STAT, 32'h1, "hstat");
        for (int i = 0; i < 4; i++) rchk(OFS_RES0 + 8'(4 * i), res(8'h3a, 2'h3), "resh");
        wr(OFS_MODE_A, 32'h0);
        wr(OFS_MODE_C, 32'h0);
        wr(OFS_IRQ_STAT, 32'h1);
        $display("test four-buffer done");
    endtask : t_buf4

    // Control write lands in the cycle the last conversion ends
    task t_stall;
        wr(OFS_IRQ_STAT, 32'h3);
        base <= 8'h44;
        stall <= 1'b1;
        wr(OFS_SEL, 32'h1);
        wr(OFS_MODE_A, CE_M | ONE_M | SCN_M);
        repeat (10) @(posedge core_clk);
        stall <= 1'b0;
        @(posedge core_clk);
        stall <= 1'b1;
        repeat (10) @(posedge core_clk);
        base <= 8'h55;
        stall <= 1'b0;
        wr(OFS_SEL, 32'h3);
        rchk(OFS_RES0, res(8'h44, 2'h0), "res0");
        rchk(OFS_RES0 + 8'h4, res(8'h3a, 2'h3), "res1");
        rchk(OFS_MODE_A, CE_M | ONE_M | SCN_M, "mode_a");
        rchk(OFS_SEL, 32'h3, "sel");
        rchk(OFS_IRQ_STAT, 32'h1 << ST_STALL_BIT, "stat");
        irqc(32'h0);
        // enable again once the stall results have been read back
        wr(OFS_MODE_A, CE_M | ONE_M | SCN_M);
        poll;
        @(posedge core_clk);
        irqc(32'h1);
        rchk(OFS_RES0 + 8'hc, res(8'h55, 2'h3), "res3");
        $display("test stall done");
    endtask : t_stall

    task wrap_up;
        $display("mismatches %0d compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        srst = 1'b1;
        {htrans, haddr, hwrite, hwdata, hw_trig, stall, base} = '0;
        fail_count = 0;
        cmp_count = 0;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset;
        t_cont;
        t_cscan;
        t_scan;
        t_buf4;
        t_stall;
        wrap_up;
    end

    // Watchdog well beyond the few hundred cycles expected
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        wrap_up;
    end
endmodule : testbench
